//--- rtl/fewc_defs.svh
// Register offsets, field positions, reset values and codes of the flash erase/write control.
`ifndef FEWC_DEFS_SVH
`define FEWC_DEFS_SVH
`define FEWC_OFF_ERASE_TRIGGER 16'h0094
`define FEWC_OFF_FLASH_CONTROL 16'h00B2
`define FEWC_OFF_ERASE_PAGE_SELECT 16'h00B7
`define FEWC_OFF_FLASH_SECURITY 16'h2702
`define FEWC_CODE_PAGE_ERASE 8'h55
`define FEWC_CODE_MASS_ERASE 8'hAA
`define FEWC_ERASE_TRIGGER_RST 8'h00
`define FEWC_PAGE_RST 6'h00
`define FEWC_KEY_RST 4'h0
`define FEWC_KEY_OPEN 4'h2
`define FEWC_CTL_PWE 0
`define FEWC_CTL_MEEN 1
`define FEWC_CTL_PSTWR 2
`define FEWC_CTL_PEND 3
`define FEWC_CTL_PROT 6
`define FEWC_SEC_WRE 1
`define FEWC_SEC_RDE 2
`define FEWC_SEC_KEY_LSB 4
`define FEWC_PAGE_LSB 2
`endif

//--- rtl/fewc_device.sv
// Flash erase/write control: the device end.
//
// Behaviour
// - Code 0x55 starts erase of selected page.
// - Code 0xAA mass-erases when armed, debug enabled.
// - Other trigger codes ignored; trigger resets zero.
// - Software re-arms bulk erase before each.
// - Page select bits 7:2 pick page 0-63.
// - Pending posted write shown; further writes dropped.
// - Deferred writes queued, run on engine-busy fall.
// - Deferred off or engine off: write immediately.
// - Select bit steers memory moves to flash.
// - Select bit self-clears after each flash byte.
// - Select bit writes ignored with interrupts enabled.
// - Read permitted bit is inverse of protect.
// - No modification unless key field equals 2.
// - Read-only external write permitted status bit.
//
// Added by the designer: the address-and-strobe port.
`include "fewc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module fewc_device (
   input wire logic CLOCK,
   input wire logic RST_N,
   fewc_if.device BUS,
   input wire logic CE_ENABLE,
   input wire logic CE_BUSY,
   input wire logic CODE_PROTECT,
   input wire logic DEBUG_PORT_ENABLE,
   input wire logic IRQ_ENABLED,
   output logic FLASH_PAGE_ERASE,
   output logic FLASH_MASS_ERASE,
   output logic [5:0] FLASH_ERASE_PAGE,
   output logic FLASH_BYTE_WRITE,
   output fewc_pkg::fewc_addr_t FLASH_WRITE_ADDR,
   output fewc_pkg::fewc_byte_t FLASH_WRITE_DATA,
   output logic EXT_WRITE_PERMITTED
);
   import fewc_pkg::*;

   logic [7:0] erase_trigger;
   logic [5:0] erase_page_select;
   logic bulk_erase_arm;
   logic deferred_write_enable;
   logic program_space_write_select;
   logic posted_write_waiting;
   logic [3:0] modify_key;
   logic ce_busy_q;
   fewc_addr_t queued_addr;
   fewc_byte_t queued_data;
   fewc_byte_t next_rdata;
   logic key_open;
   logic ce_busy_fall;
   logic byte_request;
   logic posting;
   logic wr_trig;
   logic wr_ctl;

   function automatic logic hit(input fewc_addr_t a, input fewc_addr_t off);
      return a == off;
   endfunction

   assign wr_trig = BUS.sfr_wr && hit(BUS.sfr_addr, `FEWC_OFF_ERASE_TRIGGER);
   assign wr_ctl = BUS.sfr_wr && hit(BUS.sfr_addr, `FEWC_OFF_FLASH_CONTROL);
   assign key_open = modify_key == `FEWC_KEY_OPEN;
   assign ce_busy_fall = ce_busy_q && !CE_BUSY;
   assign BUS.xmove_to_ram = !program_space_write_select;
   assign byte_request = BUS.xmove_wr && program_space_write_select && key_open &&
      !posted_write_waiting;
   assign posting = deferred_write_enable && CE_ENABLE;
   assign EXT_WRITE_PERMITTED = key_open && !CODE_PROTECT;

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         ce_busy_q <= 1'b0;
      end else begin
         ce_busy_q <= CE_BUSY;
      end
   end

   // Trigger register keeps the last code written; the code acts only in its write cycle.
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         erase_trigger <= `FEWC_ERASE_TRIGGER_RST;
      end else if (wr_trig) begin
         erase_trigger <= BUS.sfr_wdata;
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         erase_page_select <= `FEWC_PAGE_RST;
         modify_key <= `FEWC_KEY_RST;
         deferred_write_enable <= 1'b0;
      end else if (BUS.sfr_wr) begin
         if (hit(BUS.sfr_addr, `FEWC_OFF_ERASE_PAGE_SELECT)) begin
            erase_page_select <= BUS.sfr_wdata[7:`FEWC_PAGE_LSB];
         end
         if (hit(BUS.sfr_addr, `FEWC_OFF_FLASH_SECURITY)) begin
            modify_key <= BUS.sfr_wdata[7:`FEWC_SEC_KEY_LSB];
         end
         if (hit(BUS.sfr_addr, `FEWC_OFF_FLASH_CONTROL)) begin
            deferred_write_enable <= BUS.sfr_wdata[`FEWC_CTL_PSTWR];
         end
      end
   end

   // Arm bit is consumed by any mass erase trigger, so it never outlives one attempt.
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         bulk_erase_arm <= 1'b0;
      end else if (wr_ctl) begin
         bulk_erase_arm <= BUS.sfr_wdata[`FEWC_CTL_MEEN];
      end else if (wr_trig && BUS.sfr_wdata == `FEWC_CODE_MASS_ERASE) begin
         bulk_erase_arm <= 1'b0;
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         program_space_write_select <= 1'b0;
      end else if (byte_request) begin
         program_space_write_select <= 1'b0;
      end else if (wr_ctl && !IRQ_ENABLED) begin
         program_space_write_select <= BUS.sfr_wdata[`FEWC_CTL_PWE];
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         posted_write_waiting <= 1'b0;
         queued_addr <= 16'h0000;
         queued_data <= 8'h00;
      end else if (byte_request && posting) begin
         posted_write_waiting <= 1'b1;
         queued_addr <= BUS.xmove_addr;
         queued_data <= BUS.xmove_data;
      end else if (posted_write_waiting && (ce_busy_fall || !posting)) begin
         posted_write_waiting <= 1'b0;
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         FLASH_BYTE_WRITE <= 1'b0;
         FLASH_WRITE_ADDR <= 16'h0000;
         FLASH_WRITE_DATA <= 8'h00;
      end else if (byte_request && !posting) begin
         FLASH_BYTE_WRITE <= 1'b1;
         FLASH_WRITE_ADDR <= BUS.xmove_addr;
         FLASH_WRITE_DATA <= BUS.xmove_data;
      end else if (posted_write_waiting && (ce_busy_fall || !posting)) begin
         FLASH_BYTE_WRITE <= 1'b1;
         FLASH_WRITE_ADDR <= queued_addr;
         FLASH_WRITE_DATA <= queued_data;
      end else begin
         FLASH_BYTE_WRITE <= 1'b0;
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         FLASH_PAGE_ERASE <= 1'b0;
         FLASH_MASS_ERASE <= 1'b0;
         FLASH_ERASE_PAGE <= `FEWC_PAGE_RST;
      end else begin
         FLASH_PAGE_ERASE <= wr_trig && key_open && BUS.sfr_wdata == `FEWC_CODE_PAGE_ERASE;
         FLASH_MASS_ERASE <= wr_trig && key_open && bulk_erase_arm && DEBUG_PORT_ENABLE &&
            BUS.sfr_wdata == `FEWC_CODE_MASS_ERASE;
         if (wr_trig && BUS.sfr_wdata == `FEWC_CODE_PAGE_ERASE) begin
            FLASH_ERASE_PAGE <= erase_page_select;
         end
      end
   end

   always_comb begin
      next_rdata = 8'h00;
      if (hit(BUS.sfr_addr, `FEWC_OFF_FLASH_CONTROL)) begin
         next_rdata[`FEWC_CTL_PROT] = CODE_PROTECT;
         next_rdata[`FEWC_CTL_PEND] = posted_write_waiting;
         next_rdata[`FEWC_CTL_PSTWR] = deferred_write_enable;
         next_rdata[`FEWC_CTL_PWE] = program_space_write_select;
      end else if (hit(BUS.sfr_addr, `FEWC_OFF_FLASH_SECURITY)) begin
         next_rdata[7:`FEWC_SEC_KEY_LSB] = modify_key;
         next_rdata[`FEWC_SEC_RDE] = !CODE_PROTECT;
         next_rdata[`FEWC_SEC_WRE] = EXT_WRITE_PERMITTED;
      end
   end

   // Write-only registers and unmapped addresses read as zero.
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         BUS.sfr_rdata <= 8'h00;
      end else if (BUS.sfr_rd) begin
         BUS.sfr_rdata <= next_rdata;
      end else begin
         BUS.sfr_rdata <= 8'h00;
      end
   end
endmodule
`default_nettype wire

//--- rtl/fewc_host.sv
// Flash erase/write control: the processor end, passing plain-port orders onto the link.
`include "fewc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module fewc_host (
   input wire logic CLOCK,
   input wire logic RST_N,
   fewc_if.host BUS,
   input wire logic [15:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic MOVE_WR,
   input wire logic [15:0] MOVE_ADDR,
   input wire logic [7:0] MOVE_DATA,
   output logic [7:0] RDATA,
   output logic MOVE_TO_RAM
);
   import fewc_pkg::*;

   // Orders are registered once so the link sees clean one-cycle strobes.
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         BUS.sfr_wr <= 1'b0;
         BUS.sfr_rd <= 1'b0;
         BUS.sfr_addr <= 16'h0000;
         BUS.sfr_wdata <= 8'h00;
      end else begin
         BUS.sfr_wr <= WR;
         BUS.sfr_rd <= RD;
         BUS.sfr_addr <= ADDR;
         BUS.sfr_wdata <= WDATA;
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         BUS.xmove_wr <= 1'b0;
         BUS.xmove_addr <= 16'h0000;
         BUS.xmove_data <= 8'h00;
      end else begin
         BUS.xmove_wr <= MOVE_WR;
         BUS.xmove_addr <= MOVE_ADDR;
         BUS.xmove_data <= MOVE_DATA;
      end
   end

   assign RDATA = BUS.sfr_rdata;
   assign MOVE_TO_RAM = BUS.xmove_to_ram;
endmodule
`default_nettype wire

//--- rtl/fewc_if.sv
// Interface between the processor side and the flash control block.
`timescale 1ns/1ps
`default_nettype none
interface fewc_if;
   import fewc_pkg::*;
   logic sfr_wr;
   logic sfr_rd;
   fewc_addr_t sfr_addr;
   fewc_byte_t sfr_wdata;
   fewc_byte_t sfr_rdata;
   logic xmove_wr;
   fewc_addr_t xmove_addr;
   fewc_byte_t xmove_data;
   logic xmove_to_ram;
   modport device (input sfr_wr, sfr_rd, sfr_addr, sfr_wdata, xmove_wr, xmove_addr, xmove_data,
      output sfr_rdata, xmove_to_ram);
   modport host (output sfr_wr, sfr_rd, sfr_addr, sfr_wdata, xmove_wr, xmove_addr, xmove_data,
      input sfr_rdata, xmove_to_ram);
endinterface
`default_nettype wire

//--- rtl/fewc_pkg.sv
// Types shared by both ends of the flash erase/write control.
package fewc_pkg;
   typedef logic [15:0] fewc_addr_t;
   typedef logic [7:0] fewc_byte_t;
   typedef enum logic [1:0] {FEWC_OP_NONE, FEWC_OP_PAGE, FEWC_OP_MASS, FEWC_OP_BYTE} fewc_op_e;
endpackage

//--- tb/fewc_properties.sv
// Concurrent checks on the link and the device outputs.
`timescale 1ns/1ps
`default_nettype none
module fewc_properties (
   input wire logic CLOCK,
   input wire logic RST_N,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire fewc_pkg::fewc_addr_t sfr_addr,
   input wire fewc_pkg::fewc_byte_t sfr_wdata,
   input wire fewc_pkg::fewc_byte_t sfr_rdata,
   input wire logic xmove_wr,
   input wire logic xmove_to_ram,
   input wire logic CE_ENABLE,
   input wire logic CODE_PROTECT,
   input wire logic DEBUG_PORT_ENABLE,
   input wire logic FLASH_PAGE_ERASE,
   input wire logic FLASH_MASS_ERASE,
   input wire logic [5:0] FLASH_ERASE_PAGE,
   input wire logic FLASH_BYTE_WRITE
);
   import fewc_pkg::*;
   logic [3:0] key;
   logic [5:0] page;
   // Shadows of key and page, since the link carries only the writes.
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         key <= 4'h0;
         page <= 6'h00;
      end else if (sfr_wr && sfr_addr == 16'h2702) begin
         key <= sfr_wdata[7:4];
      end else if (sfr_wr && sfr_addr == 16'h00B7) begin
         page <= sfr_wdata[7:2];
      end
   end
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RST_N);
   sequence trig_s(logic [7:0] c);
      sfr_wr && sfr_addr == 16'h0094 && sfr_wdata == c;
   endsequence
   // Three quiet cycles rule out a posted write draining meanwhile.
   sequence quiet_s;
      !CE_ENABLE [*3];
   endsequence
   AST_PAGE_GO: assert property (trig_s(8'h55) ##0 key == 4'h2 |=> FLASH_PAGE_ERASE)
      else $error("page erase missing");
   AST_PAGE_NUM: assert property (FLASH_PAGE_ERASE |-> FLASH_ERASE_PAGE == $past(page))
      else $error("wrong erase page");
   AST_CODE_IGNORE: assert property (sfr_wr && sfr_addr == 16'h0094 && sfr_wdata != 8'h55
      && sfr_wdata != 8'hAA |=> !FLASH_PAGE_ERASE && !FLASH_MASS_ERASE)
      else $error("erase on bad code");
   AST_KEY_SHUT: assert property (key != 4'h2 |=> !FLASH_PAGE_ERASE && !FLASH_MASS_ERASE)
      else $error("erase while locked");
   AST_MASS_GATE: assert property (trig_s(8'hAA) ##0 !DEBUG_PORT_ENABLE |=> !FLASH_MASS_ERASE)
      else $error("mass erase without debug");
   AST_SEL_CLEAR: assert property (FLASH_BYTE_WRITE && $past(xmove_wr) |-> xmove_to_ram)
      else $error("select not cleared");
   AST_IMMEDIATE: assert property (quiet_s ##0 (xmove_wr && !xmove_to_ram && key == 4'h2)
      |=> FLASH_BYTE_WRITE)
      else $error("immediate write missing");
   AST_RDE: assert property (sfr_rd && sfr_addr == 16'h2702
      |=> sfr_rdata[2] == !$past(CODE_PROTECT))
      else $error("read permit wrong");
endmodule
`default_nettype wire

//--- tb/flash_erase_write_control_test.sv
// Self-checking bench: host and device ends joined over the link.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin err_total++; \
   $display("mismatch %s exp %h got %h", n, e, s); end end
module flash_erase_write_control_test;
   import fewc_pkg::*;
   logic CLOCK = 1'b0, RST_N = 1'b0, WR = 1'b0, RD = 1'b0, MOVE_WR = 1'b0, MOVE_TO_RAM;
   logic CE_ENABLE = 1'b0, CE_BUSY = 1'b0, CODE_PROTECT = 1'b0, DBG = 1'b0, IRQ = 1'b0;
   logic pe, me, bw, ewp;
   logic [5:0] pg;
   logic [5:0] pages [3] = '{6'h00, 6'h3F, 6'h15};
   fewc_byte_t codes [5] = '{8'h00, 8'h54, 8'h56, 8'hAB, 8'hFF};
   fewc_addr_t ADDR = 16'h0000, MOVE_ADDR = 16'h0000, fa;
   fewc_byte_t WDATA = 8'h00, MOVE_DATA = 8'h00, RDATA, v, fd;
   int err_total = 0, cmp_count = 0, cyc = 0, n_pe = 0, n_me = 0, n_bw = 0;
   fewc_if link ();
   fewc_host i_fewc_host (.CLOCK(CLOCK), .RST_N(RST_N), .BUS(link), .ADDR(ADDR), .WDATA(WDATA),
      .WR(WR), .RD(RD), .MOVE_WR(MOVE_WR), .MOVE_ADDR(MOVE_ADDR), .MOVE_DATA(MOVE_DATA),
      .RDATA(RDATA), .MOVE_TO_RAM(MOVE_TO_RAM));
   fewc_device i_fewc_device (.CLOCK(CLOCK), .RST_N(RST_N), .BUS(link), .CE_ENABLE(CE_ENABLE),
      .CE_BUSY(CE_BUSY), .CODE_PROTECT(CODE_PROTECT), .DEBUG_PORT_ENABLE(DBG),
      .IRQ_ENABLED(IRQ), .FLASH_PAGE_ERASE(pe), .FLASH_MASS_ERASE(me), .FLASH_ERASE_PAGE(pg),
      .FLASH_BYTE_WRITE(bw), .FLASH_WRITE_ADDR(fa), .FLASH_WRITE_DATA(fd),
      .EXT_WRITE_PERMITTED(ewp));
   fewc_properties i_fewc_properties (.CLOCK(CLOCK), .RST_N(RST_N), .sfr_wr(link.sfr_wr),
      .sfr_rd(link.sfr_rd), .sfr_addr(link.sfr_addr), .sfr_wdata(link.sfr_wdata),
      .sfr_rdata(link.sfr_rdata), .xmove_wr(link.xmove_wr), .xmove_to_ram(link.xmove_to_ram),
      .CE_ENABLE(CE_ENABLE), .CODE_PROTECT(CODE_PROTECT), .DEBUG_PORT_ENABLE(DBG),
      .FLASH_PAGE_ERASE(pe), .FLASH_MASS_ERASE(me), .FLASH_ERASE_PAGE(pg),
      .FLASH_BYTE_WRITE(bw));
   initial begin
      forever #12.5 CLOCK = ~CLOCK;
   end
   // Pulses are counted mid-cycle so tasks returning on an edge never race them.
   always @(negedge CLOCK) begin
      cyc++;
      if (pe) n_pe++;
      if (me) n_me++;
      if (bw) n_bw++;
      if (cyc == 2000) begin
         err_total++;
         print_verdict;
      end
   end
   task automatic print_verdict;
      if (err_total == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic wr(input fewc_addr_t a, input fewc_byte_t d);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLOCK);
      WR <= 1'b0;
      repeat (2) @(posedge CLOCK);
   endtask
   task automatic rd(input fewc_addr_t a);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLOCK);
      RD <= 1'b0;
      @(posedge CLOCK);
      @(negedge CLOCK);
      v = RDATA;
      @(posedge CLOCK);
   endtask
   task automatic mv(input fewc_addr_t a, input fewc_byte_t d);
      MOVE_ADDR <= a;
      MOVE_DATA <= d;
      MOVE_WR <= 1'b1;
      @(posedge CLOCK);
      MOVE_WR <= 1'b0;
      repeat (2) @(posedge CLOCK);
   endtask
   initial begin
      repeat (10) @(posedge CLOCK);
      RST_N <= 1'b1;
      rd(16'h2702); `CHK("security", 8'h04, v) // Locked after reset.
      wr(16'h00B7, 8'h14);
      wr(16'h0094, 8'h55);
      `CHK("locked erase", 0, n_pe) // Key shut.
      wr(16'h2702, 8'h20);
      rd(16'h2702); `CHK("security", 8'h26, v) // Write allowed.
      `CHK("write permit", 1'b1, ewp) // Key open.
      foreach (pages[i]) begin
         wr(16'h00B7, {pages[i], 2'b00});
         wr(16'h0094, 8'h55);
         `CHK("page count", i + 1, n_pe) // Page erase.
         `CHK("page", pages[i], pg) // Page field.
      end
      foreach (codes[i]) wr(16'h0094, codes[i]);
      `CHK("bad codes", 3, n_pe + n_me) // Ignored codes.
      wr(16'h00B2, 8'h02);
      wr(16'h0094, 8'hAA);
      `CHK("mass no debug", 0, n_me) // Debug gate.
      DBG <= 1'b1;
      wr(16'h0094, 8'hAA);
      `CHK("mass unarmed", 0, n_me) // Arm consumed.
      wr(16'h00B2, 8'h02);
      wr(16'h0094, 8'hAA);
      `CHK("mass", 1, n_me) // Mass erase.
      mv(16'h0100, 8'h5A);
      `CHK("ram move", 0, n_bw) // To RAM.
      wr(16'h00B2, 8'h01);
      `CHK("to ram", 1'b0, MOVE_TO_RAM) // Flash route.
      mv(16'h0123, 8'hC3);
      `CHK("byte", 1, n_bw) // Immediate.
      `CHK("addr", 16'h0123, fa) // Target.
      `CHK("data", 8'hC3, fd) // Byte.
      `CHK("cleared", 1'b1, MOVE_TO_RAM) // Self clear.
      IRQ <= 1'b1;
      wr(16'h00B2, 8'h01);
      `CHK("irq blocked", 1'b1, MOVE_TO_RAM) // Blocked.
      IRQ <= 1'b0;
      CE_ENABLE <= 1'b1;
      CE_BUSY <= 1'b1;
      wr(16'h00B2, 8'h05);
      mv(16'h0200, 8'h11);
      rd(16'h00B2); `CHK("pending", 8'h0C, v & 8'h0C) // Pending shown.
      `CHK("held", 1, n_bw) // Queued.
      wr(16'h00B2, 8'h05);
      mv(16'h0201, 8'h22);
      `CHK("dropped", 1, n_bw) // Not written while pending.
      CE_BUSY <= 1'b0;
      repeat (3) @(posedge CLOCK);
      `CHK("posted", 2, n_bw) // On busy fall.
      `CHK("posted data", 8'h11, fd) // Second dropped.
      rd(16'h00B2); `CHK("drained", 8'h04, v & 8'h0C) // Pending cleared.
      CODE_PROTECT <= 1'b1;
      rd(16'h2702); `CHK("protected", 8'h20, v) // Read shut.
      `CHK("write permit", 1'b0, ewp) // Protect blocks writes.
      RST_N <= 1'b0;
      repeat (2) @(posedge CLOCK);
      RST_N <= 1'b1;
      rd(16'h2702); `CHK("key reset", 8'h00, v) // Key cleared.
      rd(16'h00B2); `CHK("ctl reset", 8'h40, v) // Only protect shown.
      print_verdict;
   end
endmodule
`default_nettype wire
